// ===== inc/psm_pkg.sv
// Purpose: shared constants and types for the printer servo motion control
// Assumes: 40 MHz mclk_i, encoder and sensor pins squared off-chip
// Notes:   velocity tables are indexed by the remaining-count magnitude
package psm_pkg;

	localparam int          PW_DETENTS   = 192;
	localparam int          CA_DETENTS   = 400;
	localparam int          PW_AW        = 8;
	localparam int          CA_AW        = 9;
	localparam int          VEL_W        = 4;

	localparam logic [PW_AW-1:0] PW_ADDR_MAX = 8'hbf;
	localparam logic [CA_AW-1:0] CA_POS_MAX  = 9'h18f;
	localparam logic [PW_AW-1:0] PW_ZERO     = 8'h00;
	localparam logic [CA_AW-1:0] CA_ZERO     = 9'h000;
	localparam logic [VEL_W-1:0] VEL_STOP    = 4'h0;

	// squared pin inputs, index into the synchroniser vector
	localparam int          NPIN         = 8;
	localparam int          PIN_PHI1     = 0;
	localparam int          PIN_INDEX    = 1;
	localparam int          PIN_X        = 2;
	localparam int          PIN_Y        = 3;
	localparam int          PIN_LSTOP    = 4;
	localparam int          PIN_RIBBON   = 5;
	localparam int          PIN_SUPPLY   = 6;
	localparam int          PIN_MOTION   = 7;

	// deceleration profiles, indexed by top set bit of the remaining count
	localparam logic [VEL_W-1:0] PW_VEL_ROM [9] = '{
		4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf, 4'hf};
	localparam logic [VEL_W-1:0] CA_VEL_ROM [9] = '{
		4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hb, 4'he};

	localparam logic [1:0]  PAPER_IDX_RST = 2'h0;
	localparam logic [1:0]  RIBBON_RST    = 2'h1;

	typedef enum logic {PSM_POSITION, PSM_RATE} psm_mode_t;

	typedef struct packed {
		logic             dir;
		logic [PW_AW-1:0] delta;
	} psm_pw_cmd_t;

	typedef struct packed {
		logic             dir;
		logic [CA_AW-1:0] delta;
	} psm_ca_cmd_t;

endpackage

// ===== sim/psm_ctrl_model.sv
// Purpose: controller model that turns a target wheel address into a move
// Assumes: request pulses come from the bench at the falling clock edge
// Notes:   raises the move just after the rising edge that sees req_i
`timescale 1ns/100ps
`default_nettype none
module psm_ctrl_model
	import psm_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              req_i,
	input  wire logic [PW_AW-1:0]  target_i,
	input  wire logic [PW_AW-1:0]  cur_i,
	output logic                   pw_start_o,
	output psm_pw_cmd_t            pw_cmd_o
);
	int up;

	initial begin
		pw_start_o = 1'b0;
		pw_cmd_o   = '0;
	end

	// shortest way round the wheel; a tie goes clockwise
	assign up = (int'(target_i) - int'(cur_i) + PW_DETENTS)
	          % PW_DETENTS;

	// launching on the rising edge keeps the request clear of the bench's
	// own falling-edge writes to req_i; the block takes it one cycle later
	always @(posedge mclk_i) begin
		pw_start_o <= req_i;
		if (req_i && up <= PW_DETENTS / 2) begin
			pw_cmd_o <= '{dir: 1'b1, delta: PW_AW'(up)};
		end else if (req_i) begin
			pw_cmd_o <= '{dir: 1'b0, delta: PW_AW'(PW_DETENTS - up)};
		end
	end
endmodule // psm_ctrl_model
`default_nettype wire

// ===== sim/tb_psm_motion_ctrl.sv
// Purpose: self-checking bench for the motion sequencing block
// Assumes: pins are held four cycles so the synchronisers see every edge
// Notes:   the wheel direction latch resets to down, so a bare pulse wraps
`timescale 1ns/100ps
`default_nettype none
module tb_psm_motion_ctrl;
	import psm_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, ce_i = 1, req = 0, pw_start_i;
	logic ca_start_i = 0, restore_i = 0, paper_move_i = 0;
	logic paper_step_i = 0, paper_up_i = 0, ribbon_step_i = 0;
	logic [PW_AW-1:0] target = '0;
	logic [NPIN-1:0] pins_i = '0;
	psm_pw_cmd_t pw_cmd_i;
	psm_ca_cmd_t ca_cmd_i = '0;
	logic pw_pos_mode_o, pw_comp_sample_o, ca_pos_mode_o, ca_comp_sample_o;
	logic ca_drive_en_o, ca_limit_o, fault_o, paper_hold_o, ribbon_exhausted_o;
	logic paper_phase_first_o, paper_phase_second_o;
	logic ribbon_phase_first_o, ribbon_phase_second_o;
	logic [VEL_W-1:0] pw_vel_o, ca_vel_o;
	logic [PW_AW-1:0] pw_addr_o;
	logic [CA_AW-1:0] ca_detent_o;
	int n_errors = 0, comparisons = 0, n_samp = 0, n_limit = 0, moves = 0;
	int exp_addr = 0, n_ca_samp = 0;

	psm_motion_ctrl u_psm_motion_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.ce_i(ce_i), .pw_start_i(pw_start_i), .pw_cmd_i(pw_cmd_i),
		.ca_start_i(ca_start_i), .ca_cmd_i(ca_cmd_i), .restore_i(restore_i),
		.paper_move_i(paper_move_i), .paper_step_i(paper_step_i),
		.paper_up_i(paper_up_i), .ribbon_step_i(ribbon_step_i),
		.pins_i(pins_i), .pw_pos_mode_o(pw_pos_mode_o), .pw_vel_o(pw_vel_o),
		.pw_addr_o(pw_addr_o), .pw_comp_sample_o(pw_comp_sample_o),
		.ca_pos_mode_o(ca_pos_mode_o), .ca_vel_o(ca_vel_o),
		.ca_detent_o(ca_detent_o), .ca_comp_sample_o(ca_comp_sample_o),
		.ca_drive_en_o(ca_drive_en_o), .ca_limit_o(ca_limit_o),
		.fault_o(fault_o), .paper_hold_o(paper_hold_o),
		.paper_phase_first_o(paper_phase_first_o),
		.paper_phase_second_o(paper_phase_second_o),
		.ribbon_phase_first_o(ribbon_phase_first_o),
		.ribbon_phase_second_o(ribbon_phase_second_o),
		.ribbon_exhausted_o(ribbon_exhausted_o));
	psm_ctrl_model u_psm_ctrl_model (.mclk_i(mclk_i), .req_i(req),
		.target_i(target), .cur_i(pw_addr_o), .pw_start_o(pw_start_i),
		.pw_cmd_o(pw_cmd_i));

	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end

	// a one-cycle pulse adds exactly one per event
	always @(posedge mclk_i) begin
		if (pw_comp_sample_o === 1'b1) n_samp++;
		if (ca_limit_o === 1'b1) n_limit++;
		if (ca_comp_sample_o === 1'b1) n_ca_samp++;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
		end
	endtask

	function automatic int topbit(input int v);
		topbit = 0;
		for (int i = 0; i < 9; i++) if ((v >> i) & 1) topbit = i;
	endfunction

	task automatic pulse(input int idx);
		pins_i[idx] = 1'b1;
		repeat (4) @(negedge mclk_i);
		pins_i[idx] = 1'b0;
		repeat (4) @(negedge mclk_i);
	endtask

	task automatic strobe(ref logic s);
		s = 1'b1;
		@(negedge mclk_i);
		s = 1'b0;
		@(negedge mclk_i);
	endtask

	task automatic wheel_move(input int tgt, input logic dir, input int delta);
		target = PW_AW'(tgt);
		strobe(req);
		check(9'(pw_pos_mode_o), 9'h000);
		check(9'(pw_vel_o), 9'(PW_VEL_ROM[topbit(delta)]));
		for (int r = delta - 1; r >= 0; r--) begin
			pulse(PIN_PHI1);
			exp_addr = (exp_addr + (dir ? 1 : PW_DETENTS - 1)) % PW_DETENTS;
			check(9'(pw_addr_o), 9'(exp_addr));
			check(9'(pw_pos_mode_o), 9'(r == 0));
			check(9'(pw_vel_o), 9'(r ? PW_VEL_ROM[topbit(r)] : VEL_STOP));
		end
		moves++;
		check(9'(n_samp), 9'(moves));
	endtask

	task automatic test_wheel();
		pulse(PIN_PHI1);
		check(9'(pw_addr_o), 9'(PW_DETENTS - 1));
		pins_i[PIN_INDEX] = 1'b1;
		pulse(PIN_PHI1);
		pins_i[PIN_INDEX] = 1'b0;
		check(9'(pw_addr_o), 9'h000);
		check(9'(pw_pos_mode_o), 9'h001);
		wheel_move(3, 1'b1, 3);
		wheel_move(190, 1'b0, 5);
		wheel_move(94, 1'b1, 96);
		pulse(PIN_PHI1);
		check(9'(pw_pos_mode_o), 9'h001);
		exp_addr = 95;
		check(9'(pw_addr_o), 9'(exp_addr));
	endtask

	task automatic ca_go(input logic dir, input int delta);
		ca_cmd_i = '{dir: dir, delta: CA_AW'(delta)};
		strobe(ca_start_i);
		check(9'(ca_pos_mode_o), 9'h000);
		check(9'(ca_vel_o), 9'(CA_VEL_ROM[topbit(delta)]));
	endtask

	task automatic test_carriage();
		ca_go(1'b1, 2);
		pulse(PIN_X);
		check(ca_detent_o, 9'h001);
		check(9'(ca_vel_o), 9'(CA_VEL_ROM[0]));
		pulse(PIN_X);
		check(ca_detent_o, 9'h002);
		check(9'(ca_pos_mode_o), 9'h001);
		ca_go(1'b0, 1);
		pulse(PIN_X);
		check(9'(ca_pos_mode_o), 9'h000);
		pins_i[PIN_Y] = 1'b1;
		pulse(PIN_X);
		pins_i[PIN_Y] = 1'b0;
		repeat (4) @(negedge mclk_i);
		check(ca_detent_o, 9'h001);
		check(9'(ca_pos_mode_o), 9'h001);
		check(9'(ca_vel_o), 9'(VEL_STOP));
		pulse(PIN_LSTOP);
		pulse(PIN_LSTOP);
		check(9'(n_limit), 9'h002);
		check(9'(n_ca_samp), 9'h002);
	endtask

	task automatic test_fault();
		ca_go(1'b1, 3);
		pins_i[PIN_MOTION] = 1'b1;
		repeat (5) @(negedge mclk_i);
		check(9'(fault_o), 9'h001);
		check(9'(ca_drive_en_o), 9'h000);
		check(9'(ca_pos_mode_o), 9'h001);
		check(9'(n_ca_samp), 9'h002);
		pins_i[PIN_MOTION] = 1'b0;
		pins_i[PIN_SUPPLY] = 1'b1;
		repeat (4) @(negedge mclk_i);
		strobe(restore_i);
		check(9'(fault_o), 9'h001);
		target = 8'h05;
		strobe(req);
		check(9'(pw_pos_mode_o), 9'h001);
		paper_move_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		check(9'(paper_hold_o), 9'h001);
		paper_move_i = 1'b0;
		pins_i[PIN_SUPPLY] = 1'b0;
		repeat (4) @(negedge mclk_i);
		strobe(restore_i);
		check(9'(fault_o), 9'h000);
		check(9'(ca_drive_en_o), 9'h001);
	endtask

	task automatic test_paper_ribbon();
		logic [1:0] seq [8] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
		check(9'(paper_hold_o), 9'h001);
		strobe(paper_step_i);
		check(9'({paper_phase_first_o, paper_phase_second_o}), 9'h0);
		paper_move_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		check(9'(paper_hold_o), 9'h000);
		for (int i = 0; i < 8; i++) begin
			paper_up_i = (i < 4);
			strobe(paper_step_i);
			check(9'({paper_phase_first_o, paper_phase_second_o}), 9'(seq[i]));
		end
		paper_move_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		check(9'(paper_hold_o), 9'h001);
		for (int i = 0; i < 3; i++) begin
			strobe(ribbon_step_i);
			check(9'(ribbon_phase_first_o), 9'(i % 2 == 0));
			check(9'(ribbon_phase_second_o), 9'(i % 2));
		end
		ce_i = 1'b0;
		strobe(ribbon_step_i);
		ce_i = 1'b1;
		check(9'(ribbon_phase_first_o), 9'h001);
		pins_i[PIN_RIBBON] = 1'b1;
		repeat (4) @(negedge mclk_i);
		check(9'(ribbon_exhausted_o), 9'h001);
		pins_i[PIN_RIBBON] = 1'b0;
		repeat (4) @(negedge mclk_i);
		check(9'(ribbon_exhausted_o), 9'h000);
	endtask

	task automatic print_verdict();
		$display("errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// the run needs about 1000 cycles; allow ample slack
	initial begin
		#(25 * 20000);
		n_errors++;
		print_verdict();
	end

	initial begin
		repeat (5) @(negedge mclk_i);
		rst_n_i = 1'b1;
		@(negedge mclk_i);
		check(9'({pw_pos_mode_o, ca_pos_mode_o, paper_hold_o}), 9'h007);
		test_wheel();
		test_carriage();
		test_fault();
		test_paper_ribbon();
		print_verdict();
	end
endmodule // tb_psm_motion_ctrl
`default_nettype wire

// ===== verilog/psm_motion_ctrl.sv
// Purpose: printwheel/carriage servo sequencing, paper and ribbon steppers
// Assumes: controller inputs are on mclk_i; pins pass two flip-flops first
// Notes:   dir=1 means clockwise wheel, rightward carriage; paper_up_i=1 steps paper upward
`timescale 1ns/100ps
`default_nettype none
module psm_motion_ctrl
	import psm_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              pw_start_i,
	input  wire psm_pw_cmd_t       pw_cmd_i,
	input  wire logic              ca_start_i,
	input  wire psm_ca_cmd_t       ca_cmd_i,
	input  wire logic              restore_i,
	input  wire logic              paper_move_i,
	input  wire logic              paper_step_i,
	input  wire logic              paper_up_i,
	input  wire logic              ribbon_step_i,
	input  wire logic [NPIN-1:0]   pins_i,
	output logic                   pw_pos_mode_o,
	output logic [VEL_W-1:0]       pw_vel_o,
	output logic [PW_AW-1:0]       pw_addr_o,
	output logic                   pw_comp_sample_o,
	output logic                   ca_pos_mode_o,
	output logic [VEL_W-1:0]       ca_vel_o,
	output logic [CA_AW-1:0]       ca_detent_o,
	output logic                   ca_comp_sample_o,
	output logic                   ca_drive_en_o,
	output logic                   ca_limit_o,
	output logic                   fault_o,
	output logic                   paper_hold_o,
	output logic                   paper_phase_first_o,
	output logic                   paper_phase_second_o,
	output logic                   ribbon_phase_first_o,
	output logic                   ribbon_phase_second_o,
	output logic                   ribbon_exhausted_o
);
	// top set bit of a remaining count selects the profile entry
	function automatic logic [3:0] psm_bucket(input logic [CA_AW-1:0] v);
		logic [3:0] b;
		b = 4'h0;
		for (int i = 1; i < CA_AW; i++) begin
			if (v[i])
				b = 4'(i);
		end
		return b;
	endfunction
	function automatic logic [1:0] psm_paper_phase(input logic [1:0] idx);
		case (idx)
			2'h0:    return 2'b00;
			2'h1:    return 2'b10;
			2'h2:    return 2'b11;
			default: return 2'b01;
		endcase
	endfunction
	// synchronisers: meta is read only by sync
	logic [NPIN-1:0] meta, sync, last;
	logic            ca_clk_lvl, ca_clk_last, ca_dir;
	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_sync
			always_ff @(posedge mclk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta[g] <= 1'b0;
					sync[g] <= 1'b0;
					last[g] <= 1'b0;
				end else if (ce_i) begin
					meta[g] <= pins_i[g];
					sync[g] <= meta[g];
					last[g] <= sync[g];
				end
			end
		end
	endgenerate
	logic phi1_edge, lstop_edge, ca_step;
	assign phi1_edge  = sync[PIN_PHI1] & ~last[PIN_PHI1];
	assign lstop_edge = sync[PIN_LSTOP] & ~last[PIN_LSTOP];
	// the gated phase moves with direction so the count lands before the
	// detent either way; a fixed phase would leave one direction short
	always_comb begin
		ca_clk_lvl = sync[PIN_X] & (ca_dir ? ~sync[PIN_Y]
		                                   : sync[PIN_Y]);
	end
	assign ca_step = ca_clk_lvl & ~ca_clk_last;
	// fault latch
	logic fault, next_fault, fault_src;
	assign fault_src = sync[PIN_SUPPLY] | sync[PIN_MOTION];
	always_comb begin
		next_fault = fault;
		if (restore_i)
			next_fault = 1'b0;
		if (fault_src)
			next_fault = 1'b1;
	end
	// printwheel servo
	psm_mode_t        pw_mode, next_pw_mode;
	logic [PW_AW-1:0] pw_delta, next_pw_delta, pw_addr, next_pw_addr;
	logic             pw_dir, next_pw_dir, pw_go;
	logic [VEL_W-1:0] pw_vel, next_pw_vel;
	logic             pw_samp, next_pw_samp;
	assign pw_go = pw_start_i & ~fault & (pw_mode == PSM_POSITION)
	             & (pw_cmd_i.delta != PW_ZERO);
	always_comb begin
		next_pw_mode  = pw_mode;
		next_pw_delta = pw_delta;
		next_pw_dir   = pw_dir;
		next_pw_vel   = pw_vel;
		next_pw_samp  = 1'b0;
		next_pw_addr  = pw_addr;
		if (phi1_edge) begin
			if (sync[PIN_INDEX])
				next_pw_addr = PW_ZERO;
			else if (pw_dir)
				next_pw_addr = (pw_addr == PW_ADDR_MAX) ? PW_ZERO
				             : pw_addr + 8'h01;
			else
				next_pw_addr = (pw_addr == PW_ZERO) ? PW_ADDR_MAX
				             : pw_addr - 8'h01;
		end
		case (pw_mode)
			PSM_POSITION: begin
				next_pw_vel = VEL_STOP;
				if (pw_go) begin
					next_pw_mode  = PSM_RATE;
					next_pw_delta = pw_cmd_i.delta;
					next_pw_dir   = pw_cmd_i.dir;
					next_pw_vel   =
						PW_VEL_ROM[psm_bucket({1'b0, pw_cmd_i.delta})];
				end
			end
			PSM_RATE: begin
				if (phi1_edge) begin
					next_pw_delta = pw_delta - 8'h01;
					next_pw_vel   =
						PW_VEL_ROM[psm_bucket({1'b0, next_pw_delta})];
					if (pw_delta == 8'h01) begin
						next_pw_mode = PSM_POSITION;
						next_pw_vel  = VEL_STOP;
						next_pw_samp = 1'b1;
					end
				end
			end
			default: next_pw_mode = PSM_POSITION;
		endcase
	end
	// carriage servo
	psm_mode_t        ca_mode, next_ca_mode;
	logic [CA_AW-1:0] ca_delta, next_ca_delta, ca_det, next_ca_det;
	logic             next_ca_dir, ca_go;
	logic [VEL_W-1:0] ca_vel, next_ca_vel;
	logic             ca_samp, next_ca_samp;
	assign ca_go = ca_start_i & ~fault & (ca_mode == PSM_POSITION)
	             & (ca_cmd_i.delta != CA_ZERO);
	always_comb begin
		next_ca_mode  = ca_mode;
		next_ca_delta = ca_delta;
		next_ca_dir   = ca_dir;
		next_ca_vel   = ca_vel;
		next_ca_samp  = 1'b0;
		next_ca_det   = ca_det;
		if (ca_step) begin
			if (ca_dir)
				next_ca_det = (ca_det == CA_POS_MAX) ? CA_ZERO
				            : ca_det + 9'h001;
			else
				next_ca_det = (ca_det == CA_ZERO) ? CA_POS_MAX
				            : ca_det - 9'h001;
		end
		case (ca_mode)
			PSM_POSITION: begin
				next_ca_vel = VEL_STOP;
				if (ca_go) begin
					next_ca_mode  = PSM_RATE;
					next_ca_delta = ca_cmd_i.delta;
					next_ca_dir   = ca_cmd_i.dir;
					next_ca_vel   = CA_VEL_ROM[psm_bucket(ca_cmd_i.delta)];
				end
			end
			PSM_RATE: begin
				if (fault) begin
					next_ca_mode = PSM_POSITION;
					next_ca_vel  = VEL_STOP;
				end else if (ca_step) begin
					next_ca_delta = ca_delta - 9'h001;
					next_ca_vel   =
						CA_VEL_ROM[psm_bucket(next_ca_delta)];
					if (ca_delta == 9'h001) begin
						next_ca_mode = PSM_POSITION;
						next_ca_vel  = VEL_STOP;
						next_ca_samp = 1'b1;
					end
				end
			end
			default: next_ca_mode = PSM_POSITION;
		endcase
	end
	// paper and ribbon steppers
	logic       paper_hold, next_paper_hold;
	logic [1:0] paper_idx, next_paper_idx, paper_ph, next_paper_ph;
	logic [1:0] ribbon_ph, next_ribbon_ph;
	always_comb begin
		next_paper_hold = ~(paper_move_i & ~fault);
		next_paper_idx  = paper_idx;
		// stepping only once hold is already low keeps the motor locked
		if (paper_step_i & ~paper_hold & ~fault)
			next_paper_idx = paper_up_i ? paper_idx + 2'h1
			                            : paper_idx - 2'h1;
		next_paper_ph  = psm_paper_phase(next_paper_idx);
		next_ribbon_ph = ribbon_ph;
		if (ribbon_step_i & ~fault)
			next_ribbon_ph = {ribbon_ph[0], ribbon_ph[1]};
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ca_clk_last <= 1'b0;
			fault       <= 1'b0;
			pw_mode     <= PSM_POSITION;
			pw_delta    <= PW_ZERO;
			pw_dir      <= 1'b0;
			pw_vel      <= VEL_STOP;
			pw_samp     <= 1'b0;
			pw_addr     <= PW_ZERO;
			ca_mode     <= PSM_POSITION;
			ca_delta    <= CA_ZERO;
			ca_dir      <= 1'b0;
			ca_vel      <= VEL_STOP;
			ca_samp     <= 1'b0;
			ca_det      <= CA_ZERO;
			ca_limit_o  <= 1'b0;
			paper_hold  <= 1'b1;
			paper_idx   <= PAPER_IDX_RST;
			paper_ph    <= 2'b00;
			ribbon_ph   <= RIBBON_RST;
		end else if (ce_i) begin
			ca_clk_last <= ca_clk_lvl;
			fault       <= next_fault;
			pw_mode     <= next_pw_mode;
			pw_delta    <= next_pw_delta;
			pw_dir      <= next_pw_dir;
			pw_vel      <= next_pw_vel;
			pw_samp     <= next_pw_samp;
			pw_addr     <= next_pw_addr;
			ca_mode     <= next_ca_mode;
			ca_delta    <= next_ca_delta;
			ca_dir      <= next_ca_dir;
			ca_vel      <= next_ca_vel;
			ca_samp     <= next_ca_samp;
			ca_det      <= next_ca_det;
			ca_limit_o  <= lstop_edge;
			paper_hold  <= next_paper_hold;
			paper_idx   <= next_paper_idx;
			paper_ph    <= next_paper_ph;
			ribbon_ph   <= next_ribbon_ph;
		end
	end
	assign pw_pos_mode_o         = (pw_mode == PSM_POSITION);
	assign pw_vel_o              = pw_vel;
	assign pw_addr_o             = pw_addr;
	assign pw_comp_sample_o      = pw_samp;
	assign ca_pos_mode_o         = (ca_mode == PSM_POSITION);
	assign ca_vel_o              = ca_vel;
	assign ca_detent_o           = ca_det;
	assign ca_comp_sample_o      = ca_samp;
	assign ca_drive_en_o         = ~fault;
	assign fault_o               = fault;
	assign paper_hold_o          = paper_hold;
	assign paper_phase_first_o   = paper_ph[1];
	assign paper_phase_second_o  = paper_ph[0];
	assign ribbon_phase_first_o  = ribbon_ph[1];
	assign ribbon_phase_second_o = ribbon_ph[0];
	assign ribbon_exhausted_o    = sync[PIN_RIBBON];
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_pw_step;
		ce_i && phi1_edge && !sync[PIN_INDEX];
	endsequence
	sequence s_pw_last;
		ce_i && pw_mode == PSM_RATE && phi1_edge && pw_delta == 8'h01;
	endsequence
	chk_pw_stays_pos: assert property (ce_i && pw_pos_mode_o && !pw_go
		|=> pw_pos_mode_o) else $error("wheel left position mode");
	chk_addr_clear: assert property (ce_i && phi1_edge && sync[PIN_INDEX]
		|=> pw_addr_o == PW_ZERO) else $error("address not cleared");
	chk_addr_up: assert property (s_pw_step and pw_dir
		&& pw_addr != PW_ADDR_MAX |=> pw_addr_o == $past(pw_addr) + 8'h01)
		else $error("address not stepped up");
	chk_addr_wrap: assert property (s_pw_step and !pw_dir
		&& pw_addr == PW_ZERO |=> pw_addr_o == PW_ADDR_MAX)
		else $error("address wrap wrong");
	chk_pw_release: assert property (ce_i && pw_go |=> !pw_pos_mode_o
		&& pw_vel_o != VEL_STOP) else $error("move start not joint");
	chk_pw_countdown: assert property (ce_i && pw_mode == PSM_RATE
		&& phi1_edge && pw_delta > 8'h01 |=> pw_delta == $past(pw_delta)
		- 8'h01 && !pw_pos_mode_o) else $error("delta not counted");
	chk_pw_arrive: assert property (s_pw_last |=> pw_pos_mode_o
		&& pw_vel_o == VEL_STOP ##1 (!pw_comp_sample_o || !$past(ce_i)))
		else $error("wheel did not settle");
	chk_pw_sample: assert property ($rose(pw_pos_mode_o)
		|-> pw_comp_sample_o) else $error("sample strobe missing");
	chk_ca_release: assert property (ce_i && ca_go |=> !ca_pos_mode_o
		&& ca_vel_o != VEL_STOP) else $error("carriage start not joint");
	chk_ca_arrive: assert property (ce_i && ca_mode == PSM_RATE && !fault
		&& ca_step && ca_delta == 9'h001 |=> ca_pos_mode_o)
		else $error("carriage did not stop");
	chk_fault_drive: assert property (fault_o |-> !ca_drive_en_o
		##1 (ca_pos_mode_o || !$past(ce_i)))
		else $error("drive not grounded");
	chk_fault_hold: assert property (ce_i && fault_src
		|=> fault_o ##1 (fault_o || !$past(fault_src)))
		else $error("fault latch released");
	chk_paper_lock: assert property (ce_i && paper_hold
		|=> paper_idx == $past(paper_idx)) else $error("stepped while held");
endmodule // psm_motion_ctrl
`default_nettype wire
